// file: verilog/uim_regs.vh
// Purpose: Register offsets, field positions, reset values and codes for the UART interrupt and modem block.
// Assumes: A 3-bit CPU register address with one byte per address.
// Notes:   Definitions only; included by the design files.
`ifndef UIM_REGS_VH
`define UIM_REGS_VH

// Register addresses on the 3-bit CPU bus.
`define UIM_ADDR_HOLD_RECV     3'h0
`define UIM_ADDR_INT_ENABLE    3'h1
`define UIM_ADDR_INT_IDENTITY  3'h2
`define UIM_ADDR_MODEM_CONTROL 3'h4
`define UIM_ADDR_LINE_STATUS   3'h5
`define UIM_ADDR_MODEM_STATUS  3'h6
`define UIM_ADDR_SCRATCH       3'h7

// Interrupt enable fields.
`define UIM_IE_RXDATA  0
`define UIM_IE_HOLD    1
`define UIM_IE_LINE    2
`define UIM_IE_MODEM   3
`define UIM_IE_WIDTH   4

// Modem control fields.
`define UIM_MC_TERM_READY 0
`define UIM_MC_REQ_SEND   1
`define UIM_MC_AUX1       2
`define UIM_MC_AUX2       3
`define UIM_MC_LOOP       4
`define UIM_MC_WIDTH      5

// Modem status change fields; the current-state fields sit four bits higher.
`define UIM_MS_CTS_CHG  0
`define UIM_MS_DSR_CHG  1
`define UIM_MS_RING_END 2
`define UIM_MS_DCD_CHG  3

// Identification codes in bits 2:0 of the identity register.
`define UIM_ID_NONE   3'h1
`define UIM_ID_LINE   3'h6
`define UIM_ID_RXDATA 3'h4
`define UIM_ID_HOLD   3'h2
`define UIM_ID_MODEM  3'h0

// Reset values.
`define UIM_RST_IE    4'h0
`define UIM_RST_MC    5'h00
`define UIM_RST_SCR   8'h00
`define UIM_RST_BYTE  8'h00

`endif

// file: verilog/uim_sync2.v
// Purpose: Two-flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous levels; outputs are used on clk.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none

module uim_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_q;

  // Both stages reset to the idle pin level so no change is seen at reset release.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= INIT;
      dout   <= INIT;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: verilog/uim_core.v
// Purpose: Interrupt priority, interrupt enable, modem control, loopback, modem status and scratch registers.
// Assumes: CPU strobes are synchronous to clk; modem and serial pins are asynchronous.
// Notes:   Read side effects take place at the end of a read access, when the read strobe falls.
//          Read data decodes only this block's registers; other addresses read zero here.
`timescale 1ns/100ps
`default_nettype none

`include "uim_regs.vh"

// Function
// - Pending interrupts rank: line status, received data, holding empty, modem status.
// - Identity bits 2:1 give 11, 10, 01, 00 for those four sources.
// - Identity bit 0 is low while an enabled interrupt pends, else reads 001.
// - Identity register bits 3 to 7 always read zero.
// - Identity indication is frozen during its read; new events still latch.
// - Holding-empty interrupt clears on identity read as source, or holding write.
// - Enable bits 0..3 gate received data, holding empty, line, modem.
// - Enable register bits 4 to 7 always read zero.
// - Any enabled pending source drives the interrupt output; all disabled silences it.
// - Disabled sources stay out of identity and output; status still updates.
// - Control bit 0 drives terminal-ready pin inverted.
// - Control bits 1..3 drive request-to-send and auxiliaries, also inverted.
// - Loopback holds serial output marking and feeds transmit shift into receive.
// - Loopback disconnects modem inputs, routes control bits in, pins go high.
// - Loopback modem interrupts come from control bits 0-3, still enable-gated.
// - Modem control bits 5 to 7 always read zero.
// - Status bits 0,1,3 set on clear-to-send, set-ready, carrier changes; read clears.
// - Status bit 2 sets when the ring input rises low to high.
// - Any set modem change bit raises the modem interrupt condition.
// - Status bits 4-7 show inverted modem inputs, or control bits in loopback.
// - An 8-bit scratch register holds software data with no other effect.
// - Overrun, parity, framing or break events raise the line status interrupt.
// - Holding-empty sets on move to shift register, clears on holding write.
module uim_core (
  input  wire       clk,
  input  wire       arst_n,
  input  wire [2:0] busAddr,
  input  wire       busRd,
  input  wire       busWr,
  input  wire [7:0] busWrData,
  output reg  [7:0] busRdData_q,
  output reg        interruptOutput_q,
  input  wire [3:0] lineErrEvent,
  input  wire       rxDataEvent,
  input  wire       holdToShiftEvent,
  output reg        holdingEmpty_q,
  input  wire       transmitShiftOut,
  output reg        receiveShiftIn_q,
  input  wire       serialIn,
  output reg        serialOut_q,
  input  wire       clearToSend_n,
  input  wire       setReady_n,
  input  wire       ringIndicator_n,
  input  wire       carrierDetect_n,
  output reg        terminalReady_n_q,
  output reg        requestToSend_n_q,
  output reg        aux1_n_q,
  output reg        aux2_n_q
);

  // Synchronised pin levels: cts, dsr, ri, dcd, serial in.
  // Index 4 is the serial input; 0 to 3 are the modem lines in status order.
  wire [4:0] pinSync;

  // Register state. Line and receive conditions are flags set by datapath pulses,
  // so this block needs no copy of the datapath's status bits.
  reg [`UIM_IE_WIDTH-1:0] interruptEnable_q;
  reg [`UIM_MC_WIDTH-1:0] modemControl_q;
  reg [7:0]               scratchStore_q;
  reg [3:0]               modemChange_q;
  reg [3:0]               modemPrev_q;
  reg                     linePend_q;
  reg                     rxDataPend_q;
  reg                     holdPend_q;
  reg [2:0]               identity_q;
  reg                     rdPrev_q;
  reg [2:0]               rdAddr_q;

  // Combinational helpers.
  // None of them reads a pin directly; pins go through the synchroniser first.
  reg  [3:0] modemNow;
  reg  [2:0] identityNext;
  reg  [7:0] rdMux;
  wire       loopOn;
  wire       readDone;
  wire       identityBusy;
  wire       holdWrite;
  wire [3:0] enabledPend;
  wire       ringFall;
  wire [3:0] modemChangeSet;
  wire       lineStatusRead;
  wire       receiveRead;
  wire       identityRead;
  wire       modemStatusRead;
  wire       holdIdClear;

  // One synchroniser bank for every asynchronous pin input.
  // The two stages delay a pin edge by two cycles before any change bit sees it.
  uim_sync2 #(
    .WIDTH (5),
    .INIT  (5'h1f)
  ) uPinSync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({serialIn, carrierDetect_n, ringIndicator_n, setReady_n, clearToSend_n}),
    .dout   (pinSync)
  );

  assign loopOn = modemControl_q[`UIM_MC_LOOP];

  // The access ends when the read strobe falls; side effects use the latched address.
  assign readDone     = rdPrev_q & ~busRd;
  assign identityBusy = busRd & (busAddr == `UIM_ADDR_INT_IDENTITY);
  assign holdWrite    = busWr & (busAddr == `UIM_ADDR_HOLD_RECV);

  // End-of-access strobes, one for each register whose read has a side effect.
  assign lineStatusRead  = readDone & (rdAddr_q == `UIM_ADDR_LINE_STATUS);
  assign receiveRead     = readDone & (rdAddr_q == `UIM_ADDR_HOLD_RECV);
  assign identityRead    = readDone & (rdAddr_q == `UIM_ADDR_INT_IDENTITY);
  assign modemStatusRead = readDone & (rdAddr_q == `UIM_ADDR_MODEM_STATUS);

  // Identity is still frozen at this edge, so it names the source that was read.
  assign holdIdClear = identityRead & (identity_q == `UIM_ID_HOLD);

  // Track the read strobe and its address for end-of-access effects.
  // Waiting for the strobe to fall means a read held for several cycles acts once,
  // and the clear always matches the byte that the CPU took.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPrev_q <= 1'b0;
      rdAddr_q <= 3'h0;
    end else begin
      rdPrev_q <= busRd;
      if (busRd) begin
        rdAddr_q <= busAddr;
      end
    end
  end

  // Current modem line state as seen by software, active high.
  // In loopback the pins are ignored and the control bits stand in for them.
  // Entering or leaving loopback can itself set change bits, as the source swaps.
  always @* begin
    if (loopOn) begin
      modemNow[0] = modemControl_q[`UIM_MC_REQ_SEND];
      modemNow[1] = modemControl_q[`UIM_MC_TERM_READY];
      modemNow[2] = modemControl_q[`UIM_MC_AUX1];
      modemNow[3] = modemControl_q[`UIM_MC_AUX2];
    end else begin
      modemNow = ~pinSync[3:0];
    end
  end

  // A ring pin rising low to high is the complemented state falling.
  assign ringFall = modemPrev_q[2] & ~modemNow[2];

  // Change events of this cycle, one per change bit.
  assign modemChangeSet[`UIM_MS_CTS_CHG]  = modemPrev_q[0] ^ modemNow[0];
  assign modemChangeSet[`UIM_MS_DSR_CHG]  = modemPrev_q[1] ^ modemNow[1];
  assign modemChangeSet[`UIM_MS_RING_END] = ringFall;
  assign modemChangeSet[`UIM_MS_DCD_CHG]  = modemPrev_q[3] ^ modemNow[3];

  // Modem change bits: a new change wins over a clear by the same read.
  // A bit stays set until read, however often its line toggles meanwhile.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modemPrev_q   <= 4'h0;
      modemChange_q <= 4'h0;
    end else begin
      modemPrev_q <= modemNow;
      if (modemStatusRead) begin
        modemChange_q <= modemChangeSet;
      end else begin
        modemChange_q <= modemChange_q | modemChangeSet;
      end
    end
  end

  // Line status interrupt condition: any receive error event sets it.
  // Only a line status read clears it; a write there is a test path and has no effect here.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      linePend_q <= 1'b0;
    end else if (|lineErrEvent) begin
      linePend_q <= 1'b1;
    end else if (lineStatusRead) begin
      linePend_q <= 1'b0;
    end
  end

  // Received data condition: set by a new character, cleared by a buffer read.
  // A character landing as the buffer is read keeps the condition set.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxDataPend_q <= 1'b0;
    end else if (rxDataEvent) begin
      rxDataPend_q <= 1'b1;
    end else if (receiveRead) begin
      rxDataPend_q <= 1'b0;
    end
  end

  // Holding-empty status and interrupt; a move into the shift register wins a same-cycle clear.
  // The status resets to one, but the interrupt waits for a real move.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      holdingEmpty_q <= 1'b1;
      holdPend_q     <= 1'b0;
    end else if (holdToShiftEvent) begin
      holdingEmpty_q <= 1'b1;
      holdPend_q     <= 1'b1;
    end else begin
      if (holdWrite) begin
        holdingEmpty_q <= 1'b0;
      end
      if (holdWrite) begin
        holdPend_q <= 1'b0;
      end else if (holdIdClear) begin
        holdPend_q <= 1'b0;
      end
    end
  end

  // Gate each source by its enable bit before it can be reported.
  // Index order is priority order, which the encoder below relies on.
  assign enabledPend[0] = linePend_q   & interruptEnable_q[`UIM_IE_LINE];
  assign enabledPend[1] = rxDataPend_q & interruptEnable_q[`UIM_IE_RXDATA];
  assign enabledPend[2] = holdPend_q   & interruptEnable_q[`UIM_IE_HOLD];
  assign enabledPend[3] = (|modemChange_q) & interruptEnable_q[`UIM_IE_MODEM];

  // Fixed priority encoder; disabled sources never appear.
  // Earlier tests win, so a lower source waits until the higher ones clear.
  always @* begin
    if (enabledPend[0]) begin
      identityNext = `UIM_ID_LINE;
    end else if (enabledPend[1]) begin
      identityNext = `UIM_ID_RXDATA;
    end else if (enabledPend[2]) begin
      identityNext = `UIM_ID_HOLD;
    end else if (enabledPend[3]) begin
      identityNext = `UIM_ID_MODEM;
    end else begin
      identityNext = `UIM_ID_NONE;
    end
  end

  // The reported code holds still while software is reading it, so the byte it
  // gets and the clear it triggers agree; sources keep latching meanwhile.
  // The output flag is not frozen, so a new source may raise it during the read.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      identity_q        <= `UIM_ID_NONE;
      interruptOutput_q <= 1'b0;
    end else begin
      if (!identityBusy) begin
        identity_q <= identityNext;
      end
      interruptOutput_q <= |enabledPend;
    end
  end

  // Writable registers; a write to the identity address falls through untouched.
  // Datapath addresses fall to the default too; narrow registers keep only low bits.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interruptEnable_q <= `UIM_RST_IE;
      modemControl_q    <= `UIM_RST_MC;
      scratchStore_q    <= `UIM_RST_SCR;
    end else if (busWr) begin
      case (busAddr)
        `UIM_ADDR_INT_ENABLE: begin
          interruptEnable_q <= busWrData[`UIM_IE_WIDTH-1:0];
        end
        `UIM_ADDR_MODEM_CONTROL: begin
          modemControl_q <= busWrData[`UIM_MC_WIDTH-1:0];
        end
        `UIM_ADDR_SCRATCH: begin
          scratchStore_q <= busWrData;
        end
        default: begin
          scratchStore_q <= scratchStore_q;
        end
      endcase
    end
  end

  // Read data for this block's registers; other addresses belong to the datapath and read zero here.
  // The status byte shows the live line state above the sticky change bits.
  always @* begin
    case (busAddr)
      `UIM_ADDR_INT_IDENTITY:  rdMux = {5'h00, identity_q};
      `UIM_ADDR_INT_ENABLE:    rdMux = {4'h0, interruptEnable_q};
      `UIM_ADDR_MODEM_CONTROL: rdMux = {3'h0, modemControl_q};
      `UIM_ADDR_MODEM_STATUS:  rdMux = {modemNow[3], modemNow[2], modemNow[1], modemNow[0],
                                        modemChange_q};
      `UIM_ADDR_SCRATCH:       rdMux = scratchStore_q;
      default:                 rdMux = `UIM_RST_BYTE;
    endcase
  end

  // Read data is registered each cycle the strobe is high and parks at zero otherwise.
  // Parking at zero keeps a stale byte off the bus once the access ends.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdData_q <= `UIM_RST_BYTE;
    end else if (busRd) begin
      busRdData_q <= rdMux;
    end else begin
      busRdData_q <= `UIM_RST_BYTE;
    end
  end

  // Modem control pins are active low; loopback parks them at the inactive high level.
  // The control bits are kept in loopback, so leaving it restores the pins at once.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      terminalReady_n_q <= 1'b1;
      requestToSend_n_q <= 1'b1;
      aux1_n_q          <= 1'b1;
      aux2_n_q          <= 1'b1;
    end else begin
      terminalReady_n_q <= loopOn | ~modemControl_q[`UIM_MC_TERM_READY];
      requestToSend_n_q <= loopOn | ~modemControl_q[`UIM_MC_REQ_SEND];
      aux1_n_q          <= loopOn | ~modemControl_q[`UIM_MC_AUX1];
      aux2_n_q          <= loopOn | ~modemControl_q[`UIM_MC_AUX2];
    end
  end

  // Serial loopback path; costs one cycle of latency in each direction, far below a bit time.
  // The serial pin is ignored in loopback, so line noise cannot reach the receiver.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serialOut_q      <= 1'b1;
      receiveShiftIn_q <= 1'b1;
    end else begin
      serialOut_q      <= loopOn | transmitShiftOut;
      receiveShiftIn_q <= loopOn ? transmitShiftOut : pinSync[4];
    end
  end

endmodule

`default_nettype wire

// file: verilog/placeholder_unused.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: bench/uim_core_chk.sv
// Purpose: Port-level assertions for the interrupt, modem control and scratch block.
// Assumes: Read data is registered one cycle after the read strobe is sampled.
// Notes:   Sees only top-level ports, so control state is inferred from bus writes.
`timescale 1ns/100ps
`default_nettype none

module uim_core_chk (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [2:0] busAddr,
  input wire logic       busRd,
  input wire logic       busWr,
  input wire logic [7:0] busWrData,
  input wire logic [7:0] busRdData_q,
  input wire logic       holdToShiftEvent,
  input wire logic       holdingEmpty_q,
  input wire logic       serialOut_q,
  input wire logic       terminalReady_n_q,
  input wire logic       requestToSend_n_q,
  input wire logic       aux1_n_q,
  input wire logic       aux2_n_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // One sampled read cycle of a given register.
  sequence regRead(a);
    busRd && busAddr == a;
  endsequence

  // A control write with the loopback bit clear, carrying the written byte.
  property pinsFollow;
    logic [7:0] d;
    (busWr && busAddr == 3'h4 && !busWrData[4], d = busWrData) |->
      ##2 {aux2_n_q, aux1_n_q, requestToSend_n_q, terminalReady_n_q} == ~d[3:0];
  endproperty

  // Scratch write, one cycle without a write, then its read back.
  property scratchKeeps;
    logic [7:0] d;
    (busWr && busAddr == 3'h7, d = busWrData) ##1 !busWr ##1 regRead(3'h7) |=> busRdData_q == d;
  endproperty

  AST_ID_ZERO: assert property (regRead(3'h2) |=> busRdData_q[7:3] == 5'h00)
    else $error("identity upper bits not zero");
  AST_IE_ZERO: assert property (regRead(3'h1) |=> busRdData_q[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  AST_MC_ZERO: assert property (regRead(3'h4) |=> busRdData_q[7:5] == 3'h0)
    else $error("control upper bits not zero");
  AST_ID_FREEZE: assert property (regRead(3'h2) ##1 regRead(3'h2) |=> $stable(busRdData_q))
    else $error("identity changed during its read");
  AST_PIN_INV: assert property (pinsFollow)
    else $error("modem pins not inverse of control bits");
  AST_LOOP_PINS: assert property (busWr && busAddr == 3'h4 && busWrData[4] |-> ##2
    {serialOut_q, terminalReady_n_q, requestToSend_n_q, aux1_n_q, aux2_n_q} == 5'h1f)
    else $error("pins not high in loopback");
  AST_HOLD_SET: assert property (holdToShiftEvent |=> holdingEmpty_q)
    else $error("holding empty not set on move");
  AST_HOLD_CLR: assert property (busWr && busAddr == 3'h0 && !holdToShiftEvent |=> !holdingEmpty_q)
    else $error("holding empty not cleared on load");
  AST_SCRATCH: assert property (scratchKeeps)
    else $error("scratch read back differs");
  AST_RD_IDLE: assert property (!busRd |=> busRdData_q == 8'h00)
    else $error("read data not zero when idle");
endmodule

bind uim_core uim_core_chk u_chk (.clk(clk), .arst_n(arst_n), .busAddr(busAddr), .busRd(busRd), .busWr(busWr),
  .busWrData(busWrData), .busRdData_q(busRdData_q), .holdToShiftEvent(holdToShiftEvent),
  .holdingEmpty_q(holdingEmpty_q), .serialOut_q(serialOut_q), .terminalReady_n_q(terminalReady_n_q),
  .requestToSend_n_q(requestToSend_n_q), .aux1_n_q(aux1_n_q), .aux2_n_q(aux2_n_q));

`default_nettype wire

// file: bench/uim_modem_model.sv
// Purpose: Modem and transmitter stand-in on the far side of the block.
// Assumes: Line levels and ring requests come from the bench.
// Notes:   The shift output toggles every cycle so a stale loop path shows at once.
`timescale 1ns/100ps
`default_nettype none

module uim_modem_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] lineLvl_n,
  input  wire logic       ringReq,
  input  wire logic       serLvl,
  output logic            clearToSend_n,
  output logic            setReady_n,
  output logic            carrierDetect_n,
  output logic            ringIndicator_n,
  output logic            serialIn,
  output var logic        transmitShiftOut
);
  // Toggling pattern stands in for transmitted bits.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transmitShiftOut <= 1'b0;
    end else begin
      transmitShiftOut <= ~transmitShiftOut;
    end
  end

  // Active-low modem lines; a ring request pulls the ring line low.
  assign {carrierDetect_n, setReady_n, clearToSend_n} = lineLvl_n;
  assign ringIndicator_n = ~ringReq;
  assign serialIn = serLvl;
endmodule

`default_nettype wire

// file: bench/uim_core_test.sv
// Purpose: Self-checking bench for the interrupt, modem control and scratch block.
// Assumes: Clock of 25 ns; inputs change 1 ns after the rising edge.
// Notes:   Each scenario is one task that drives and judges before returning.
`timescale 1ns/100ps
`default_nettype none

module uim_core_test;
  logic       clk, arst_n, busRd, busWr, rxDataEvent, holdToShiftEvent, ringReq, serLvl, transmitShiftOut;
  logic       interruptOutput_q, holdingEmpty_q, receiveShiftIn_q, serialIn, serialOut_q;
  logic       clearToSend_n, setReady_n, ringIndicator_n, carrierDetect_n;
  logic       terminalReady_n_q, requestToSend_n_q, aux1_n_q, aux2_n_q;
  logic [2:0] busAddr, lineLvl_n;
  logic [3:0] lineErrEvent;
  logic [7:0] busWrData, busRdData_q, rv;
  int         failures, cmp_count;

  uim_core u_dut (.clk(clk), .arst_n(arst_n), .busAddr(busAddr), .busRd(busRd), .busWr(busWr),
    .busWrData(busWrData), .busRdData_q(busRdData_q), .interruptOutput_q(interruptOutput_q),
    .lineErrEvent(lineErrEvent), .rxDataEvent(rxDataEvent), .holdToShiftEvent(holdToShiftEvent),
    .holdingEmpty_q(holdingEmpty_q), .transmitShiftOut(transmitShiftOut), .receiveShiftIn_q(receiveShiftIn_q),
    .serialIn(serialIn), .serialOut_q(serialOut_q), .clearToSend_n(clearToSend_n), .setReady_n(setReady_n),
    .ringIndicator_n(ringIndicator_n), .carrierDetect_n(carrierDetect_n), .terminalReady_n_q(terminalReady_n_q),
    .requestToSend_n_q(requestToSend_n_q), .aux1_n_q(aux1_n_q), .aux2_n_q(aux2_n_q));
  uim_modem_model u_modem (.clk(clk), .arst_n(arst_n), .lineLvl_n(lineLvl_n), .ringReq(ringReq),
    .serLvl(serLvl), .clearToSend_n(clearToSend_n), .setReady_n(setReady_n), .carrierDetect_n(carrierDetect_n),
    .ringIndicator_n(ringIndicator_n), .serialIn(serialIn), .transmitShiftOut(transmitShiftOut));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    busAddr = a;
    busWrData = d;
    busWr = 1'b1;
    @(posedge clk) #1;
    busWr = 1'b0;
  endtask

  // A read ends with an idle edge so its side effect has landed on return.
  task automatic rdchk(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    busAddr = a;
    busRd = 1'b1;
    @(posedge clk) #1;
    rv = busRdData_q;
    busRd = 1'b0;
    @(posedge clk) #1;
    check(nm, rv, e);
  endtask

  // One-cycle event pulse {hold, rx, line[3:0]}, then two edges for pend and output.
  task automatic ev(input logic [5:0] v);
    @(posedge clk) #1;
    {holdToShiftEvent, rxDataEvent, lineErrEvent} = v;
    @(posedge clk) #1;
    {holdToShiftEvent, rxDataEvent, lineErrEvent} = 6'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    check("interrupt_output", {7'h0, interruptOutput_q}, 8'h00);
    check("hold empty", {7'h0, holdingEmpty_q}, 8'h01);
    check("pins", {3'h0, serialOut_q, terminalReady_n_q, requestToSend_n_q, aux1_n_q, aux2_n_q}, 8'h1f);
    rdchk("ie", 3'h1, 8'h00);
    rdchk("mc", 3'h4, 8'h00);
    rdchk("scr", 3'h7, 8'h00);
    rdchk("id", 3'h2, 8'h01);
    rdchk("ms", 3'h6, 8'h00);
  endtask

  task automatic t_regs;
    wr(3'h1, 8'hff);
    rdchk("ie", 3'h1, 8'h0f);
    wr(3'h4, 8'he5);
    rdchk("mc", 3'h4, 8'h05);
    check("pins", {3'h0, serialOut_q, terminalReady_n_q, requestToSend_n_q, aux1_n_q, aux2_n_q},
      {3'h0, ~transmitShiftOut, 4'h5});
    wr(3'h7, 8'ha5);
    rdchk("scr", 3'h7, 8'ha5);
    wr(3'h2, 8'hff);
    rdchk("id", 3'h2, 8'h01);
    wr(3'h4, 8'h00);
  endtask

  // Raise three sources, then peel them off from the top. Software reads addresses 2, 5 and 0.
  task automatic t_prio;
    wr(3'h1, 8'h0f);
    ev(6'h20);
    check("interrupt_output", {7'h0, interruptOutput_q}, 8'h01);
    rdchk("id", 3'h2, 8'h02);
    ev(6'h10);
    ev(6'h02);
    ev(6'h20);
    rdchk("id", 3'h2, 8'h06);
    rdchk("ls", 3'h5, 8'h00);
    rdchk("id", 3'h2, 8'h04);
    rdchk("rb", 3'h0, 8'h00);
    rdchk("id", 3'h2, 8'h02);
    rdchk("id", 3'h2, 8'h01);
    check("interrupt_output", {7'h0, interruptOutput_q}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ev(6'h01 << i);
      rdchk("id", 3'h2, 8'h06);
      rdchk("ls", 3'h5, 8'h00);
    end
    @(posedge clk) #1;
    busAddr = 3'h2;
    busRd = 1'b1;
    rxDataEvent = 1'b1;
    @(posedge clk) #1;
    rxDataEvent = 1'b0;
    repeat (3) @(posedge clk);
    #1 check("frozen id", busRdData_q, 8'h01);
    busRd = 1'b0;
    rdchk("id", 3'h2, 8'h04);
    rdchk("rb", 3'h0, 8'h00);
  endtask

  task automatic t_mask;
    wr(3'h1, 8'h00);
    ev(6'h10);
    check("interrupt_output", {7'h0, interruptOutput_q}, 8'h00);
    rdchk("id", 3'h2, 8'h01);
    wr(3'h1, 8'h01);
    repeat (2) @(posedge clk);
    #1 check("interrupt_output", {7'h0, interruptOutput_q}, 8'h01);
    rdchk("rb", 3'h0, 8'h00);
    ev(6'h20);
    wr(3'h1, 8'h02);
    rdchk("id", 3'h2, 8'h02);
    ev(6'h20);
    wr(3'h0, 8'h55);
    check("hold empty", {7'h0, holdingEmpty_q}, 8'h00);
    rdchk("id", 3'h2, 8'h01);
  endtask

  task automatic t_modem;
    wr(3'h1, 8'h08);
    lineLvl_n = 3'h6;
    repeat (6) @(posedge clk);
    #1 check("interrupt_output", {7'h0, interruptOutput_q}, 8'h01);
    rdchk("id", 3'h2, 8'h00);
    rdchk("ms", 3'h6, 8'h11);
    rdchk("ms", 3'h6, 8'h10);
    lineLvl_n = 3'h0;
    repeat (6) @(posedge clk);
    rdchk("ms", 3'h6, 8'hba);
    ringReq = 1'b1;
    repeat (6) @(posedge clk);
    rdchk("ms", 3'h6, 8'hf0);
    ringReq = 1'b0;
    repeat (6) @(posedge clk);
    rdchk("ms", 3'h6, 8'hb4);
    wr(3'h4, 8'h19);
    repeat (4) @(posedge clk);
    #1 check("pins", {3'h0, serialOut_q, terminalReady_n_q, requestToSend_n_q, aux1_n_q, aux2_n_q}, 8'h1f);
    check("loop rx", {7'h0, receiveShiftIn_q}, {7'h0, ~transmitShiftOut});
    rdchk("ms", 3'h6, 8'ha1);
    wr(3'h4, 8'h1d);
    rdchk("ms", 3'h6, 8'he0);
    wr(3'h4, 8'h19);
    repeat (2) @(posedge clk);
    #1 check("interrupt_output", {7'h0, interruptOutput_q}, 8'h01);
    rdchk("ms", 3'h6, 8'ha4);
    wr(3'h4, 8'h00);
    repeat (6) @(posedge clk);
    rdchk("ms", 3'h6, 8'hb1);
    check("rx", {7'h0, receiveShiftIn_q}, 8'h00);
  endtask

  task automatic complete_run;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence; every input is set at time zero.
  initial begin
    {arst_n, busRd, busWr, rxDataEvent, holdToShiftEvent, ringReq, serLvl} = 7'h00;
    {busAddr, busWrData, lineErrEvent, lineLvl_n} = 18'h00007;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    t_reset();
    t_regs();
    t_prio();
    t_mask();
    t_modem();
    complete_run();
  end

  // The scenarios need well under 1000 cycles; this cuts a hang short.
  initial begin
    #100us;
    failures++;
    complete_run();
  end
endmodule

`default_nettype wire
